// >>> rtl/phy_ms_status_mdix_ctrl.sv
// Master/slave status and crossover control register bank
// Notes on behaviour
// RULE1 - Config fault flag latches high, cleared by reading the status register.
// RULE2 - Fault flag also clears on autoneg enable and on autoneg complete.
// RULE3 - Fault flag sets when failed resolutions reach seven.
// RULE4 - Fault flag sets when both ends forced to the same role.
// RULE5 - Status bit shows resolved role: one master, zero slave.
// RULE6 - Read-only bit shows local receiver health, one is OK.
// RULE7 - Read-only bit shows remote receiver health, one is OK.
// RULE8 - Two bits show partner gigabit full and half duplex ability.
// RULE9 - Software trusts duplex bits only while page received reads one.
// RULE10 - Eight-bit counter counts each idle error.
// RULE11 - Idle error counter saturates at all ones.
// RULE12 - Crossover field: 00 straight, 01 crossed, 11 auto; resets to auto.
// RULE13 - A written crossover mode takes effect only at software reset.
// RULE14 - Software read-modify-writes, keeping unused control fields intact.
// RULE15 - Idle error counter clears when status register is read.
// RULE16 - Page received latches high until software reads it.
// RULE17 - Manual role is used in resolution after autoneg restart.
// RULE18 - Transmitter test mode allowed only once auto crossover is disabled.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`include "phy_ms_defs.svh"
module phy_ms_status_mdix_ctrl
#(
  parameter int CNT_WIDTH = 8
)
(
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // Register port
  input wire phy_ms_pkg::reg_addr_t ADDR_I,
  input wire phy_ms_pkg::reg_word_t WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output phy_ms_pkg::reg_word_t RDATA_O,
  // Negotiation and line events (same clock)
  input wire logic AN_ENABLE_I,
  input wire logic AN_COMPLETE_I,
  input wire logic AN_RESTART_I,
  input wire logic RESOLVE_FAIL_I,
  input wire logic PAGE_RX_I,
  input wire logic PAGE_RX_READ_I,
  input wire logic SOFT_RESET_I,
  input wire logic IDLE_ERR_I,
  input wire logic MANUAL_EN_I,
  input wire logic MANUAL_MASTER_I,
  input wire logic PARTNER_FORCED_I,
  input wire logic PARTNER_MASTER_I,
  input wire logic PARTNER_PREF_MASTER_I,
  input wire logic LOCAL_PREF_MASTER_I,
  input wire logic LOCAL_RX_OK_I,
  input wire logic REMOTE_RX_OK_I,
  input wire logic LP_FULL_I,
  input wire logic LP_HALF_I,
  input wire logic TEST_REQ_I,
  // Status outputs
  output phy_ms_pkg::xover_t XOVER_MODE_O,
  output logic ROLE_MASTER_O,
  output logic PAGE_RECEIVED_O,
  output logic TEST_MODE_EN_O,
  output logic IRQ_O
);
  import phy_ms_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic cfg_fault;
  logic [2:0] fail_count;
  logic use_manual;
  logic manual_master;
  logic local_rx_ok;
  logic remote_rx_ok;
  logic lp_full;
  logic lp_half;
  logic an_enable_d;
  reg_word_t ext_ctrl;
  logic [`IRQ_BITS-1:0] irq_status;
  logic [`IRQ_BITS-1:0] irq_mask;
  logic [CNT_WIDTH-1:0] idle_count;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------

  // True when the bus address selects the given register offset
  function automatic logic hits(input reg_addr_t a, input reg_addr_t ofs);
    hits = (a == ofs);
  endfunction

  // One select per mapped register, shared by read and write decode
  wire sel_status = hits(ADDR_I, `OFS_MS_STATUS);
  wire sel_ctrl = hits(ADDR_I, `OFS_EXT_CTRL1);
  wire sel_irq_status = hits(ADDR_I, `OFS_IRQ_STATUS);
  wire sel_irq_mask = hits(ADDR_I, `OFS_IRQ_MASK);

  // Strobe qualified selects; the status word has no write decode
  wire rd_status = RD_I && sel_status;
  wire wr_ctrl = WR_I && sel_ctrl;
  wire wr_irq_status = WR_I && sel_irq_status;
  wire wr_irq_mask = WR_I && sel_irq_mask;
  wire an_enable_rise = AN_ENABLE_I && !an_enable_d;

  // Resolution: manual roles clash, or preference by role
  wire both_forced = use_manual && PARTNER_FORCED_I &&
    (manual_master == PARTNER_MASTER_I); // RULE4
  wire fail_hit = RESOLVE_FAIL_I &&
    (fail_count == `FAIL_LIMIT - 3'h1); // RULE3
  wire fault_set = both_forced || fail_hit;
  wire fault_clr = rd_status || an_enable_rise || AN_COMPLETE_I; // RULE1 RULE2
  wire next_fault = fault_set ? 1'b1 : (fault_clr ? 1'b0 : cfg_fault);
  wire next_role = use_manual ? manual_master :
    (LOCAL_PREF_MASTER_I || !PARTNER_PREF_MASTER_I); // RULE5 RULE17

  // Crossover field and test gate
  wire [1:0] ctrl_xover = ext_ctrl[`POS_XOVER_HI:`POS_XOVER_LO];
  wire auto_off = XOVER_MODE_O != XOVER_AUTO;
  wire next_test = TEST_REQ_I && auto_off; // RULE18

  // Interrupt events: fault set, page received, counter saturated
  wire sat_hit = IDLE_ERR_I && (&idle_count);
  wire [`IRQ_BITS-1:0] irq_event = {sat_hit, PAGE_RX_I, fault_set};
  wire [`IRQ_BITS-1:0] next_irq_status =
    irq_event | (irq_status & ~(wr_irq_status ? WDATA_I[`IRQ_BITS-1:0] :
    {`IRQ_BITS{1'b0}}));

  // Status word assembly
  wire [15:0] status_word = {cfg_fault, ROLE_MASTER_O, local_rx_ok,
    remote_rx_ok, lp_full, lp_half, 2'b00, idle_count}; // RULE6 RULE7 RULE8

  // Interrupt words, zero padded to the bus width
  wire [15:0] irq_status_word = {{(16-`IRQ_BITS){1'b0}}, irq_status};
  wire [15:0] irq_mask_word = {{(16-`IRQ_BITS){1'b0}}, irq_mask};

  // Read multiplexer, unmapped addresses read zero
  wire [15:0] next_rdata =
    !RD_I ? 16'h0000 :
    sel_status ? status_word :
    sel_ctrl ? ext_ctrl :
    sel_irq_status ? irq_status_word :
    sel_irq_mask ? irq_mask_word : 16'h0000;

  // ----------------------------------------------------------------
  // Idle error counter
  // ----------------------------------------------------------------
  idle_err_counter #(.WIDTH(CNT_WIDTH)) u_idle_cnt
  (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .err_i(IDLE_ERR_I),
    .clear_i(rd_status),
    .count_o(idle_count)
  );

  // ----------------------------------------------------------------
  // Fault flag and failure count
  // ----------------------------------------------------------------

  // Fault flag: a set in the same cycle as a clear still latches
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      cfg_fault <= 1'b0;
    else
      cfg_fault <= next_fault; // RULE1
  end

  // Delayed enable level, used to find the enable edge
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      an_enable_d <= 1'b0;
    else
      an_enable_d <= AN_ENABLE_I;
  end

  // Failed resolution count, restarted by autoneg enable, autoneg complete and the seventh failure, not by a negotiation restart
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      fail_count <= 3'h0;
    else if (AN_COMPLETE_I || an_enable_rise || fail_hit)
      fail_count <= 3'h0;
    else if (RESOLVE_FAIL_I)
      fail_count <= fail_count + 3'h1; // RULE3
  end

  // Manual role settings, sampled only when negotiation restarts
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      use_manual <= 1'b0;
      manual_master <= 1'b1;
    end
    else if (AN_RESTART_I)
    begin
      use_manual <= MANUAL_EN_I; // RULE17
      manual_master <= MANUAL_MASTER_I;
    end
  end

  // Resolved role, updated once per completed negotiation
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      ROLE_MASTER_O <= 1'b0;
    else if (AN_COMPLETE_I)
      ROLE_MASTER_O <= next_role; // RULE5
  end

  // Receiver and partner ability levels, one cycle behind the inputs
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      local_rx_ok <= 1'b0;
      remote_rx_ok <= 1'b0;
      lp_full <= 1'b0;
      lp_half <= 1'b0;
    end
    else
    begin
      local_rx_ok <= LOCAL_RX_OK_I; // RULE6
      remote_rx_ok <= REMOTE_RX_OK_I; // RULE7
      lp_full <= LP_FULL_I; // RULE8
      lp_half <= LP_HALF_I;
    end
  end

  // Page received flag: set wins over the read clear
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      PAGE_RECEIVED_O <= 1'b0;
    else if (PAGE_RX_I)
      PAGE_RECEIVED_O <= 1'b1; // RULE16
    else if (PAGE_RX_READ_I)
      PAGE_RECEIVED_O <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Extended control and applied crossover mode
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      ext_ctrl <= `RST_EXT_CTRL1; // RULE12
      XOVER_MODE_O <= XOVER_AUTO;
    end
    else
    begin
      if (wr_ctrl)
        ext_ctrl <= WDATA_I; // RULE14
      if (SOFT_RESET_I)
        XOVER_MODE_O <= xover_t'(ctrl_xover); // RULE13 RULE12
    end
  end

  // Test mode gate
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      TEST_MODE_EN_O <= 1'b0;
    else
      TEST_MODE_EN_O <= next_test; // RULE18
  end

  // ----------------------------------------------------------------
  // Interrupts and read data
  // ----------------------------------------------------------------

  // Sticky event bits, an event beats a same-cycle write-one clear
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      irq_status <= '0;
    else
      irq_status <= next_irq_status;
  end

  // Interrupt mask, same layout as the event bits
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      irq_mask <= '0;
    else if (wr_irq_mask)
      irq_mask <= WDATA_I[`IRQ_BITS-1:0];
  end

  // Level interrupt, registered so the pin never glitches
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      IRQ_O <= 1'b0;
    else
      IRQ_O <= |(next_irq_status & irq_mask);
  end

  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      RDATA_O <= 16'h0000;
    else
      RDATA_O <= next_rdata;
  end

endmodule

// >>> rtl/phy_ms_defs.svh
// Offsets, field positions, reset values and counts of the status/control bank
`ifndef PHY_MS_DEFS_SVH
`define PHY_MS_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_MS_STATUS 5'h0a
`define OFS_EXT_CTRL1 5'h10
`define OFS_IRQ_STATUS 5'h18
`define OFS_IRQ_MASK 5'h19

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define POS_CFG_FAULT 15
`define POS_ROLE 14
`define POS_LOCAL_RX 13
`define POS_REMOTE_RX 12
`define POS_LP_FULL 11
`define POS_LP_HALF 10
`define POS_XOVER_LO 5
`define POS_XOVER_HI 6

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define RST_EXT_CTRL1 16'h0078
`define FAIL_LIMIT 3'h7
`define IRQ_BITS 3

`endif

// >>> rtl/phy_ms_pkg.sv
// Types shared by the status/control bank
package phy_ms_pkg;
  typedef enum logic [1:0] {
    XOVER_STRAIGHT = 2'b00,
    XOVER_CROSSED = 2'b01,
    XOVER_NONE = 2'b10,
    XOVER_AUTO = 2'b11
  } xover_t;
  typedef logic [4:0] reg_addr_t;
  typedef logic [15:0] reg_word_t;
endpackage

// >>> rtl/idle_err_counter.sv
// Saturating idle error counter, cleared on read
`timescale 1ns/1ns
module idle_err_counter
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Events
  input wire logic err_i,
  input wire logic clear_i,
  // Count
  output logic [WIDTH-1:0] count_o
);

  // Next count: clear wins, then count up while below all ones
  wire at_max = &count_o;
  wire [WIDTH-1:0] next_count = clear_i ? '0 :
    ((err_i && !at_max) ? count_o + 1'b1 : count_o); // RULE10 RULE11 RULE15

  // Count register
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      count_o <= '0;
    else
      count_o <= next_count;
  end

endmodule

// >>> test/phy_ms_checker.sv
// Port-level checker for the status and crossover bank
`timescale 1ns/1ns
module phy_ms_checker
(
  // Clock, reset and register port
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire phy_ms_pkg::reg_addr_t ADDR_I,
  input wire logic RD_I,
  input wire phy_ms_pkg::reg_word_t RDATA_O,
  // Events and status
  input wire logic IDLE_ERR_I,
  input wire logic SOFT_RESET_I,
  input wire phy_ms_pkg::xover_t XOVER_MODE_O,
  input wire logic TEST_REQ_I,
  input wire logic TEST_MODE_EN_O,
  input wire logic LOCAL_RX_OK_I,
  input wire logic REMOTE_RX_OK_I,
  input wire logic LP_FULL_I,
  input wire logic LP_HALF_I,
  input wire logic AN_COMPLETE_I,
  input wire logic ROLE_MASTER_O,
  input wire logic PAGE_RX_I,
  input wire logic PAGE_RX_READ_I,
  input wire logic PAGE_RECEIVED_O
);
  import phy_ms_pkg::*;
  // Status read strobe and receiver and partner ability level inputs
  wire logic rd_st = RD_I && ADDR_I == 5'h0a;
  wire logic [3:0] rx = {LOCAL_RX_OK_I, REMOTE_RX_OK_I, LP_FULL_I, LP_HALF_I};
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  property p_rd_quiet;
    !$past(RD_I) |-> RDATA_O == 16'h0000;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not idle");
  property p_rx_bits;
    rd_st && $stable(rx) |=> RDATA_O[13:10] == $past(rx);
  endproperty
  a_rx_bits: assert property (p_rx_bits) else $error("rx bits wrong");
  property p_cnt_clear;
    rd_st && !IDLE_ERR_I ##1 rd_st && !IDLE_ERR_I |=> RDATA_O[7:0] == 8'h00;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("count kept");
  property p_xover_hold;
    $changed(XOVER_MODE_O) |-> $past(SOFT_RESET_I);
  endproperty
  a_xover_hold: assert property (p_xover_hold) else $error("early mode");
  property p_test_gate;
    TEST_MODE_EN_O |-> $past(TEST_REQ_I) && $past(XOVER_MODE_O) != XOVER_AUTO;
  endproperty
  a_test_gate: assert property (p_test_gate) else $error("test mode");
  property p_role_hold;
    $changed(ROLE_MASTER_O) |-> $past(AN_COMPLETE_I);
  endproperty
  a_role_hold: assert property (p_role_hold) else $error("role moved");
  property p_page_set;
    PAGE_RX_I && !PAGE_RX_READ_I |=> PAGE_RECEIVED_O;
  endproperty
  a_page_set: assert property (p_page_set) else $error("page not set");
  property p_page_clr;
    $fell(PAGE_RECEIVED_O) |-> $past(PAGE_RX_READ_I);
  endproperty
  a_page_clr: assert property (p_page_clr) else $error("page lost");
endmodule
bind phy_ms_status_mdix_ctrl phy_ms_checker chk_i (.*);

// >>> test/tb.sv
// Directed bench for the status and crossover bank
`timescale 1ns/1ns
module tb;
  import phy_ms_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, role, page, test_en, irq;
  reg_addr_t addr = '0;
  reg_word_t wdata = '0, rdata;
  xover_t xmode;
  logic [6:0] ev = '0;
  logic [11:0] lv = '0;
  logic [1:0] m, prev = 2'b11;
  int failures = 0, checks_done = 0, cyc = 0;
  // Clock
  always #2 clk = ~clk;
  phy_ms_status_mdix_ctrl dut (.REF_CLK_I(clk), .RSTN_I(rst_n),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .AN_ENABLE_I(lv[0]), .AN_COMPLETE_I(ev[0]), .AN_RESTART_I(ev[1]),
    .RESOLVE_FAIL_I(ev[2]), .PAGE_RX_I(ev[3]), .PAGE_RX_READ_I(ev[4]),
    .SOFT_RESET_I(ev[5]), .IDLE_ERR_I(ev[6]), .MANUAL_EN_I(lv[1]),
    .MANUAL_MASTER_I(lv[2]), .PARTNER_FORCED_I(lv[3]),
    .PARTNER_MASTER_I(lv[4]), .PARTNER_PREF_MASTER_I(lv[5]),
    .LOCAL_PREF_MASTER_I(lv[6]), .LOCAL_RX_OK_I(lv[7]),
    .REMOTE_RX_OK_I(lv[8]), .LP_FULL_I(lv[9]), .LP_HALF_I(lv[10]),
    .TEST_REQ_I(lv[11]), .XOVER_MODE_O(xmode), .ROLE_MASTER_O(role),
    .PAGE_RECEIVED_O(page), .TEST_MODE_EN_O(test_en), .IRQ_O(irq));
  // ----
  // Tasks
  // ----
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr_reg(input reg_addr_t a, input reg_word_t d);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task rd_reg(input reg_addr_t a, input reg_word_t e, input reg_word_t k);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata & k, e);
  endtask
  task fire(input int b, input int n);
    repeat (n)
    begin
      ev[b] <= 1;
      @(posedge clk);
      ev[b] <= 0;
      @(posedge clk);
    end
  endtask
  task conclude();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      conclude();
    end
  end
  // ----
  // Scenarios
  // ----
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd_reg(5'h10, 16'h0078, 16'hffff);
    chk({14'h0, xmode}, 16'h0003);
    rd_reg(5'h0a, 16'h0000, 16'hffff);
    rd_reg(5'h03, 16'h0000, 16'hffff);
    fire(6, 3);
    rd_reg(5'h0a, 16'h0003, 16'h00ff);
    rd_reg(5'h0a, 16'h0000, 16'h00ff);
    fire(6, 260);
    rd_reg(5'h0a, 16'h00ff, 16'h00ff);
    fire(0, 1);
    fire(2, 6);
    rd_reg(5'h0a, 16'h0000, 16'h8000);
    fire(2, 1);
    rd_reg(5'h0a, 16'h8000, 16'h8000);
    rd_reg(5'h0a, 16'h0000, 16'h8000);
    fire(2, 7);
    lv[0] <= 1;
    @(posedge clk);
    rd_reg(5'h0a, 16'h0000, 16'h8000);
    fire(2, 7);
    fire(0, 1);
    rd_reg(5'h0a, 16'h0000, 16'h8000);
    lv[2:1] <= 2'b01;
    fire(1, 1);
    fire(0, 1);
    chk({15'h0, role}, 16'h0000);
    lv[4:1] <= 4'b1111;
    fire(1, 1);
    fire(0, 1);
    rd_reg(5'h0a, 16'hc000, 16'hc000);
    lv[10:7] <= 4'b0111;
    fire(3, 1);
    chk({15'h0, page}, 16'h0001);
    repeat (2) @(posedge clk);
    rd_reg(5'h0a, 16'h3800, 16'h3c00);
    for (int i = 0; i < 3; i++)
    begin
      m = (i == 2) ? 2'b11 : 2'(i);
      wr_reg(5'h10, {9'h0, m, 5'h18});
      rd_reg(5'h10, {9'h0, m, 5'h18}, 16'hffff);
      chk({14'h0, xmode}, {14'h0, prev});
      fire(5, 1);
      chk({14'h0, xmode}, {14'h0, m});
      lv[11] <= 1;
      repeat (2) @(posedge clk);
      #1 chk({15'h0, test_en}, {15'h0, m != 2'b11});
      lv[11] <= 0;
      prev = m;
    end
    fire(3, 1);
    chk({15'h0, page}, 16'h0001);
    fire(4, 1);
    chk({15'h0, page}, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    wr_reg(5'h19, 16'h0002);
    repeat (2) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0001);
    rd_reg(5'h18, 16'h0002, 16'h0002);
    wr_reg(5'h18, 16'h0002);
    repeat (2) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0000);
    conclude();
  end
endmodule
